// >>> design/bcc_pkg.sv
// Constants, types and helpers shared by the CPU bus cycle controller
package bcc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  // Least reset hold that the driver of resetn must give, in clock cycles
  localparam int RST_MIN_CYC = 3;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic IRQ_ENABLE_OUT_RST = 1'b0;
  // Positions in the synchronised pin vector
  localparam int PIN_PHI1 = 0;
  localparam int PIN_PHI2 = 1;
  localparam int PIN_READY = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_IRQ = 4;
  localparam int PIN_DATA = 5;
  localparam int PIN_W = PIN_DATA + DATA_W;
  // Register byte addresses
  localparam logic [31:0] OFF_CMD = 32'h0000_0000;
  localparam logic [31:0] OFF_ADDR = 32'h0000_0004;
  localparam logic [31:0] OFF_WDATA = 32'h0000_0008;
  localparam logic [31:0] OFF_STAT = 32'h0000_000c;
  localparam logic [31:0] OFF_PC = 32'h0000_0010;
  localparam logic [31:0] OFF_SP = 32'h0000_0014;
  localparam logic [2:0] AHB_WORD = 3'h2;
  // Command register fields
  localparam int CMD_KIND = 0;
  localparam int CMD_GO = 3;
  localparam int CMD_EI = 4;
  localparam int CMD_DI = 5;
  localparam int CMD_IEND = 6;
  // Status register fields
  localparam int STA_BUSY = 8;
  localparam int STA_HALTED = 9;
  localparam int STA_WAIT = 10;
  localparam int STA_BUS_GRANT_ACK = 11;
  localparam int STA_IRQ_ENABLE_OUT = 12;
  localparam int STA_INTACC = 13;
  // Status byte bits driven in the first clock state
  localparam int SB_INTA = 0;
  localparam int SB_WO_N = 1;
  localparam int SB_STACK = 2;
  localparam int SB_HLTA = 3;
  localparam int SB_OUT = 4;
  localparam int SB_M1 = 5;
  localparam int SB_INP = 6;
  localparam int SB_MEMR = 7;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_T1 = 7'h02, ST_T2 = 7'h04, ST_TW = 7'h08,
    ST_T3 = 7'h10, ST_HOLD = 7'h20, ST_HALT = 7'h40
  } bcc_state_t;

  typedef enum logic [2:0] {
    CK_FETCH = 3'h0, CK_MEMRD = 3'h1, CK_MEMWR = 3'h2, CK_STKRD = 3'h3,
    CK_STKWR = 3'h4, CK_INRD = 3'h5, CK_OUTWR = 3'h6, CK_HALT = 3'h7
  } bcc_kind_t;

  function automatic logic kind_is_wr(input bcc_kind_t k);
    return (k == CK_MEMWR) || (k == CK_STKWR) || (k == CK_OUTWR);
  endfunction

  function automatic logic kind_is_rd(input bcc_kind_t k);
    return (k == CK_FETCH) || (k == CK_MEMRD) || (k == CK_STKRD) || (k == CK_INRD);
  endfunction
endpackage

// >>> design/bcc_pin_if.sv
// Synchronised pin levels and their rising edges
`timescale 1ns/1ps
`default_nettype none
interface bcc_pin_if #(parameter int W = 13);
  wire [W-1:0] lvl;
  wire [W-1:0] rise;
  modport src (output lvl, output rise);
  modport dst (input lvl, input rise);
endinterface // bcc_pin_if
`default_nettype wire

// >>> design/bcc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge detect
`timescale 1ns/1ps
`default_nettype none
module bcc_pin_sync #(
  parameter int W = 13
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] raw,
  bcc_pin_if.src sp
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_reg, s2_reg, s3_reg, lvl_reg, old_reg;
    // A level counts only once stages two and three agree
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s1_reg <= 1'b0;
        s2_reg <= 1'b0;
        s3_reg <= 1'b0;
        lvl_reg <= 1'b0;
        old_reg <= 1'b0;
      end else if (ce) begin
        s1_reg <= raw[i];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg == s3_reg) lvl_reg <= s3_reg;
        old_reg <= lvl_reg;
      end
    end
    assign sp.lvl[i] = lvl_reg;
    assign sp.rise[i] = lvl_reg & ~old_reg;
  end
endmodule // bcc_pin_sync
`default_nettype wire

// >>> design/bcc_cycle_ctrl.sv
// Bus cycle controller: machine-cycle pins, wait, hold, interrupt enable
// How it works
// - drive 16-bit address: memory address or one of 256 in/out ports
// - 8-bit two-way data bus, bit zero least significant
// - first clock state of each cycle except halt puts the cycle status byte out
// - cycle-start output marks the start of each machine cycle except halt
// - bus-input strobe high in the second, wait and third states of read cycles
// - without ready after the address, stay in wait state while low
// - wait-acknowledge output high while in the wait state
// - write strobe low for writes, data stable all the while
// - hold request seen only when halted, or second/wait state with ready
// - in the granted state address and data buses float
// - grant acknowledge starts in third state for reads, after it for writes
// - grant after first-phase rise, float after following second-phase rise
// - enable flip-flop set and cleared by command, shown on a pin, gates interrupts
// - accepted interrupt clears enable in first state of the fetch cycle
// - interrupt request sampled at instruction end or while halted
// - interrupt ignored while granted or while enable is clear
// - reset clears program counter, enable and grant flip-flops
// - reset leaves the stack pointer unchanged and clears the address and data registers
// - sixteen-bit stack pointer addresses a stack in outside memory
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bcc_cycle_ctrl (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic phi1,
  input wire logic phi2,
  input wire logic ready,
  input wire logic hold,
  input wire logic irq,
  input wire logic [bcc_pkg::DATA_W-1:0] data_lines_in,
  output logic [bcc_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  output logic [bcc_pkg::ADDR_W-1:0] address_lines,
  output logic address_oe,
  output logic sync,
  output logic bus_input_strobe,
  output logic wait_ack,
  output logic wr_n,
  output logic bus_grant_ack,
  output logic irq_enable_out
);
  import bcc_pkg::*;

  logic rst_m_reg, rst_n_reg;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_m_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_n_reg <= rst_m_reg;
    end
  end

  bcc_pin_if #(.W(PIN_W)) pin_bus ();
  bcc_pin_sync #(.W(PIN_W)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n_reg),
    .ce(ce),
    .raw({data_lines_in, irq, hold, ready, phi2, phi1}),
    .sp(pin_bus.src)
  );
  wire p1r = pin_bus.rise[PIN_PHI1];
  wire p2r = pin_bus.rise[PIN_PHI2];
  wire rdy = pin_bus.lvl[PIN_READY];
  wire hold_l = pin_bus.lvl[PIN_HOLD];
  wire irq_l = pin_bus.lvl[PIN_IRQ];
  wire [DATA_W-1:0] din = pin_bus.lvl[PIN_DATA +: DATA_W];

  bcc_state_t state_reg, state_next;
  bcc_kind_t kind_reg, req_kind_reg;
  logic req_pend_reg, halted_reg, hold_pend_reg, bus_grant_ack_reg, float_reg;
  logic irq_enable_out_reg, int_acc_reg;
  logic [ADDR_W-1:0] addr_reg, pc_reg, sp_reg, bus_addr_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg, dout_reg;
  logic [31:0] hrdata_reg;
  logic [5:0] wsel_reg;

  wire st_idle = (state_reg == ST_IDLE);
  wire st_t1 = (state_reg == ST_T1);
  wire st_t2 = (state_reg == ST_T2);
  wire st_tw = (state_reg == ST_TW);
  wire st_t3 = (state_reg == ST_T3);
  wire st_hold = (state_reg == ST_HOLD);
  wire st_halt = (state_reg == ST_HALT);
  wire cur_rd = kind_is_rd(kind_reg);
  wire cur_wr = kind_is_wr(kind_reg);
  wire busy = req_pend_reg | ~st_idle;

  // AHB-Lite slave, zero wait states while enabled
  wire ahb_take = hsel & hready & htrans[1] & (hsize == AHB_WORD);
  wire hit_cmd = ahb_take & (haddr == OFF_CMD);
  wire hit_addr = ahb_take & (haddr == OFF_ADDR);
  wire hit_wdata = ahb_take & (haddr == OFF_WDATA);
  wire hit_stat = ahb_take & (haddr == OFF_STAT);
  wire hit_pc = ahb_take & (haddr == OFF_PC);
  wire hit_sp = ahb_take & (haddr == OFF_SP);
  wire wr_cmd = wsel_reg[0];
  wire wr_addr = wsel_reg[1];
  wire wr_wdata = wsel_reg[2];
  wire wr_pc = wsel_reg[4];
  wire wr_sp = wsel_reg[5];
  wire go_cmd = wr_cmd & hwdata[CMD_GO] & ~busy;
  wire ei_cmd = wr_cmd & hwdata[CMD_EI];
  // Disable outranks enable when both come in one write
  wire di_cmd = wr_cmd & hwdata[CMD_DI];
  wire iend_cmd = wr_cmd & hwdata[CMD_IEND];

  wire [31:0] stat_word;
  assign stat_word[DATA_W-1:0] = rdata_reg;
  assign stat_word[STA_BUSY] = busy;
  assign stat_word[STA_HALTED] = halted_reg;
  assign stat_word[STA_WAIT] = st_tw;
  assign stat_word[STA_BUS_GRANT_ACK] = bus_grant_ack_reg;
  assign stat_word[STA_IRQ_ENABLE_OUT] = irq_enable_out_reg;
  assign stat_word[STA_INTACC] = int_acc_reg;
  assign stat_word[31:STA_INTACC+1] = '0;

  wire [31:0] rd_word = hit_addr ? {16'h0000, addr_reg} :
                        hit_wdata ? {24'h00_0000, wdata_reg} :
                        hit_stat ? stat_word :
                        hit_pc ? {16'h0000, pc_reg} :
                        hit_sp ? {16'h0000, sp_reg} : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      wsel_reg <= 6'h00;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce) begin
      wsel_reg <= hwrite ? {hit_sp, hit_pc, hit_stat, hit_wdata, hit_addr, hit_cmd} : 6'h00;
      hrdata_reg <= (ahb_take & ~hwrite) ? rd_word : 32'h0000_0000;
    end
  end
  // Freezing the block also stalls the bus so no write is lost
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (ce) begin
      if (wr_addr) addr_reg <= hwdata[ADDR_W-1:0];
      if (wr_wdata) wdata_reg <= hwdata[DATA_W-1:0];
    end
  end

  // Machine cycle sequencing, paced by first-phase rises
  wire leave_t2 = p1r & (st_t2 | st_tw) & rdy;
  wire int_take;
  always_comb begin
    state_next = state_reg;
    if (p1r) begin
      case (state_reg)
        ST_IDLE: begin
          if (req_pend_reg) state_next = (req_kind_reg == CK_HALT) ? ST_HALT : ST_T1;
        end
        ST_T1: state_next = ST_T2;
        ST_T2, ST_TW: state_next = rdy ? ST_T3 : ST_TW;
        ST_T3: state_next = hold_pend_reg ? ST_HOLD : ST_IDLE;
        ST_HOLD: begin
          if (!hold_l) state_next = halted_reg ? ST_HALT : ST_IDLE;
        end
        ST_HALT: begin
          if (hold_l) state_next = ST_HOLD;
          else if (int_take) state_next = ST_IDLE;
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end
  wire start = st_idle & (state_next == ST_T1);
  wire start_fetch = start & (req_kind_reg == CK_FETCH);

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) state_reg <= ST_IDLE;
    else if (ce) state_reg <= state_next;
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      req_pend_reg <= 1'b0;
      req_kind_reg <= CK_FETCH;
      kind_reg <= CK_FETCH;
    end else if (ce) begin
      if (go_cmd) begin
        req_pend_reg <= 1'b1;
        req_kind_reg <= bcc_kind_t'(hwdata[CMD_KIND +: 3]);
      end else if (st_idle & p1r) begin
        req_pend_reg <= 1'b0;
      end
      if (start) kind_reg <= req_kind_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) halted_reg <= 1'b0;
    else if (ce) halted_reg <= (state_next == ST_HALT) | (halted_reg & (state_next == ST_HOLD));
  end

  wire [ADDR_W-1:0] port_addr = {{(ADDR_W-PORT_W){1'b0}}, addr_reg[PORT_W-1:0]};
  wire [ADDR_W-1:0] sp_dec = sp_reg - 16'h0001;
  wire [ADDR_W-1:0] cyc_addr = (req_kind_reg == CK_FETCH) ? pc_reg :
                               (req_kind_reg == CK_STKRD) ? sp_reg :
                               (req_kind_reg == CK_STKWR) ? sp_dec :
                               ((req_kind_reg == CK_INRD) | (req_kind_reg == CK_OUTWR)) ? port_addr :
                               addr_reg;

  wire [DATA_W-1:0] status_byte;
  assign status_byte[SB_INTA] = (req_kind_reg == CK_FETCH) & int_acc_reg;
  assign status_byte[SB_WO_N] = ~kind_is_wr(req_kind_reg);
  assign status_byte[SB_STACK] = (req_kind_reg == CK_STKRD) | (req_kind_reg == CK_STKWR);
  assign status_byte[SB_HLTA] = 1'b0;
  assign status_byte[SB_OUT] = (req_kind_reg == CK_OUTWR);
  assign status_byte[SB_M1] = (req_kind_reg == CK_FETCH);
  assign status_byte[SB_INP] = (req_kind_reg == CK_INRD);
  assign status_byte[SB_MEMR] = kind_is_rd(req_kind_reg) & (req_kind_reg != CK_INRD);

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bus_addr_reg <= 16'h0000;
      dout_reg <= 8'h00;
    end else if (ce) begin
      if (start) bus_addr_reg <= cyc_addr;
      if (start) dout_reg <= status_byte;
      else if (st_t1 & p1r) dout_reg <= wdata_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) rdata_reg <= 8'h00;
    else if (ce & leave_t2 & cur_rd) rdata_reg <= din;
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) pc_reg <= PC_RST;
    else if (ce) begin
      if (wr_pc) pc_reg <= hwdata[ADDR_W-1:0];
      else if (start_fetch & ~int_acc_reg) pc_reg <= pc_reg + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce) begin
      if (wr_sp) sp_reg <= hwdata[ADDR_W-1:0];
      else if (start & (req_kind_reg == CK_STKWR)) sp_reg <= sp_dec;
      else if (start & (req_kind_reg == CK_STKRD)) sp_reg <= sp_reg + 16'h0001;
    end
  end

  assign int_take = (iend_cmd | (st_halt & p1r)) & irq_l & irq_enable_out_reg & ~bus_grant_ack_reg & ~int_acc_reg;
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) int_acc_reg <= 1'b0;
    else if (ce) begin
      if (int_take) int_acc_reg <= 1'b1;
      else if (start_fetch) int_acc_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) irq_enable_out_reg <= IRQ_ENABLE_OUT_RST;
    else if (ce) begin
      if (di_cmd | (start_fetch & int_acc_reg)) irq_enable_out_reg <= 1'b0;
      else if (ei_cmd) irq_enable_out_reg <= 1'b1;
    end
  end

  wire hold_seen = hold_l & leave_t2;
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) hold_pend_reg <= 1'b0;
    else if (ce) begin
      if (hold_seen) hold_pend_reg <= 1'b1;
      else if (state_next == ST_HOLD) hold_pend_reg <= 1'b0;
    end
  end

  wire bus_grant_ack_set = p1r & ((hold_seen & cur_rd) | (st_t3 & hold_pend_reg & cur_wr) | (st_halt & hold_l));
  wire bus_grant_ack_clr = p1r & st_hold & ~hold_l;
  always_ff @(posedge mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      bus_grant_ack_reg <= 1'b0;
      float_reg <= 1'b0;
    end else if (ce) begin
      if (bus_grant_ack_set) bus_grant_ack_reg <= 1'b1;
      else if (bus_grant_ack_clr) bus_grant_ack_reg <= 1'b0;
      if (bus_grant_ack_clr) float_reg <= 1'b0;
      else if (p2r & bus_grant_ack_reg) float_reg <= 1'b1;
    end
  end

  assign sync = st_t1;
  assign bus_input_strobe = cur_rd & (st_t2 | st_tw | st_t3);
  assign wait_ack = st_tw;
  assign wr_n = ~(cur_wr & st_t3);
  assign data_lines_oe = ~float_reg & (st_t1 | (cur_wr & (st_t2 | st_tw | st_t3)));
  assign data_lines_out = dout_reg;
  assign address_lines = bus_addr_reg;
  assign address_oe = ~float_reg;
  assign bus_grant_ack = bus_grant_ack_reg;
  assign irq_enable_out = irq_enable_out_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_reg);

  status_on_sync_a: assert property (sync |-> data_lines_oe && data_lines_out[SB_WO_N] == !cur_wr)
    else $error("status byte not on the bus with cycle start");
  wait_entry_a: assert property (ce && st_t2 && p1r && !rdy |=> wait_ack)
    else $error("no wait state without ready");
  wait_stay_a: assert property (ce && st_tw && !rdy |=> wait_ack)
    else $error("wait state left while ready low");
  strobe_dir_a: assert property (bus_input_strobe |-> !data_lines_oe)
    else $error("input strobe while driving data");
  write_stable_a: assert property (!wr_n && $past(!wr_n) |-> $stable(data_lines_out) && data_lines_oe)
    else $error("write data moved under strobe");
  float_order_a: assert property ($rose(float_reg) |-> bus_grant_ack && $past(p2r))
    else $error("float without grant and second phase");
  float_bus_a: assert property (float_reg |-> !address_oe && !data_lines_oe)
    else $error("bus driven while floated");
  irq_enable_out_clear_a: assert property (st_t1 && data_lines_out[SB_INTA] |-> !irq_enable_out)
    else $error("enable still set in acknowledge fetch");
  hold_when_a: assert property ($rose(hold_pend_reg) |-> $past(st_t2 || st_tw) && $past(rdy))
    else $error("hold recognised in wrong state");
  grant_start_a: assert property ($rose(bus_grant_ack_reg) |-> (st_t3 && cur_rd) || st_hold)
    else $error("grant began at wrong state");
  int_gate_a: assert property ($rose(int_acc_reg) |-> $past(irq_enable_out_reg) && !$past(bus_grant_ack_reg))
    else $error("interrupt taken while masked or granted");

  read_wait_c: cover property (st_tw && cur_rd ##1 st_t3);
  write_c: cover property (!wr_n ##1 wr_n && st_idle);
  hold_c: cover property ($rose(float_reg));
  int_c: cover property (st_t1 && data_lines_out[SB_INTA]);
endmodule // bcc_cycle_ctrl
`default_nettype wire

// >>> tb/bcc_mem_model.sv
// Memory and I/O model with phase clocks and ready pacing for the bus cycle controller
`timescale 1ns/1ps
`default_nettype none
module bcc_mem_model (
  input wire logic mclk,
  input wire logic [1:0] nwait,
  input wire logic [15:0] address_lines,
  input wire logic [7:0] data_lines_out,
  input wire logic data_lines_oe,
  input wire logic bus_input_strobe,
  input wire logic sync,
  input wire logic wr_n,
  output logic phi1,
  output logic phi2,
  output logic ready,
  output logic [7:0] data_lines_in,
  output logic [15:0] last_wa,
  output logic [7:0] last_wd,
  output logic wr_bad
);
  logic [7:0] mem [int];
  logic [3:0] ph = 4'h0;
  logic [1:0] left = 2'h0;
  logic seen = 1'b0;
  logic wr_q = 1'b1;
  wire bus_ph = bus_input_strobe | (data_lines_oe & ~sync);
  function automatic logic [7:0] rd(input logic [15:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  initial begin
    {phi1, phi2, ready, wr_bad} = 4'h0;
    data_lines_in = 8'h00;
    last_wa = 16'h0000;
    last_wd = 8'h00;
  end
  always @(posedge mclk) begin
    ph <= (ph == 4'h9) ? 4'h0 : ph + 4'h1;
    phi1 <= (ph == 4'h9) || (ph == 4'h0);
    phi2 <= (ph >= 4'h2) && (ph <= 4'h6);
  end
  // ready mid-state, held low for the asked number of wait states
  always @(posedge mclk) begin
    if (ph == 4'h7) begin
      if (!bus_ph) begin
        seen <= 1'b0;
        ready <= 1'b0;
      end else if (!seen) begin
        seen <= 1'b1;
        left <= nwait;
        ready <= (nwait == 2'h0);
      end else if (left != 2'h0) begin
        left <= left - 2'h1;
        ready <= (left == 2'h1);
      end
    end
  end
  // data only under the input strobe; otherwise a toggling pattern, not the last value
  always @(posedge mclk) data_lines_in <= bus_input_strobe ? rd(address_lines) : ~data_lines_in;
  always @(posedge mclk) begin
    wr_q <= wr_n;
    if (!wr_n && wr_q) begin
      last_wa <= address_lines;
      last_wd <= data_lines_out;
    end
    if (!wr_n && !wr_q && (data_lines_out !== last_wd || address_lines !== last_wa)) wr_bad <= 1'b1;
    if (wr_n && !wr_q) mem[last_wa] = last_wd;
  end
endmodule // bcc_mem_model
`default_nettype wire

// >>> tb/cpu_bus_cycle_control_bench.sv
// Self-checking bench: machine cycles, wait states, hold, interrupt enable, reset
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_cycle_control_bench;
  import bcc_pkg::*;
  logic mclk = 0, resetn = 0, hsel = 0, hwrite = 0, hold = 0, irq = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0, nwait = 0;
  logic [2:0] hsize = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, phi1, phi2, ready, data_lines_oe, address_oe, sync, bus_input_strobe;
  wire wait_ack, wr_n, bus_grant_ack, irq_enable_out, wr_bad;
  wire [7:0] data_lines_in, data_lines_out, last_wd;
  wire [15:0] address_lines, last_wa;
  logic sync_q = 0, gnt_q = 0, aoe_q = 1, st_ie = 0;
  logic [7:0] st_b = 0;
  logic [15:0] st_a = 0;
  int tc = 0, t_g = 0, t_f = 0, n_w = 0, n_sync = 0, n_fail = 0, n_tests = 0, pc, sp, ra, wd;
  logic [7:0] mem_m [int];

  always #50 mclk = ~mclk;

  bcc_cycle_ctrl dut (.mclk, .resetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .phi1, .phi2, .ready, .hold, .irq, .data_lines_in,
    .data_lines_out, .data_lines_oe, .address_lines, .address_oe, .sync, .bus_input_strobe, .wait_ack,
    .wr_n, .bus_grant_ack, .irq_enable_out);
  bcc_mem_model far (.mclk, .nwait, .address_lines, .data_lines_out, .data_lines_oe, .bus_input_strobe,
    .sync, .wr_n, .phi1, .phi2, .ready, .data_lines_in, .last_wa, .last_wd, .wr_bad);

  // Times are counted from the cycle-start rise
  always @(posedge mclk) begin
    sync_q <= sync;
    gnt_q <= bus_grant_ack;
    aoe_q <= address_oe;
    tc <= (sync && !sync_q) ? 1 : tc + 1;
    if (sync && !sync_q) begin
      n_sync <= n_sync + 1;
      st_b <= data_lines_out;
      st_a <= address_lines;
      st_ie <= irq_enable_out;
    end
    if (bus_grant_ack && !gnt_q) t_g <= tc;
    if (!address_oe && aoe_q) t_f <= tc;
    if (wait_ack) n_w <= n_w + 1;
  end

  task automatic test_done();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= AHB_WORD;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    r = hrdata;
    chk("hresp", hresp, 0);
  endtask
  task automatic wreg(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1, a, d, x);
  endtask
  task automatic rchk(input string w, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(0, a, 0, x);
    chk(w, x, e);
  endtask
  task automatic stat(input string w, input int b, input logic e);
    logic [31:0] x;
    bus(0, OFF_STAT, 0, x);
    chk(w, x[b], e);
  endtask
  function automatic logic [7:0] mval(input int a);
    return mem_m.exists(a) ? mem_m[a] : a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [7:0] sbyte(input int k, input bit ia);
    logic [7:0] s;
    s = 8'h00;
    s[SB_INTA] = ia;
    s[SB_WO_N] = !(k == 2 || k == 4 || k == 6);
    s[SB_STACK] = (k == 3 || k == 4);
    s[SB_OUT] = (k == 6);
    s[SB_M1] = (k == 0);
    s[SB_INP] = (k == 5);
    s[SB_MEMR] = (k <= 1 || k == 3);
    return s;
  endfunction

  // One machine cycle of kind k with nw wait states, optionally granting the bus
  task automatic cyc(input int k, input int nw, input bit hk, input bit ia);
    int ns, w0, e;
    logic [31:0] x;
    e = (k == 0) ? pc : (k == 3) ? sp : (k == 4) ? sp - 1 : (k >= 5) ? (ra & 255) : ra;
    e = e & 16'hffff;
    ns = n_sync;
    w0 = n_w;
    nwait <= nw[1:0];
    hold <= hk;
    wreg(OFF_CMD, 32'(k) | 32'h8);
    while (n_sync == ns) @(posedge mclk);
    chk("status", st_b, sbyte(k, ia));
    chk("addr", st_a, e);
    if (hk) begin
      while (bus_grant_ack !== 1'b1) @(posedge mclk);
      repeat (12) @(posedge mclk);
      chk("float", {address_oe, data_lines_oe}, 0);
      chk("grant at", t_g, (k == 2 ? 30 : 20) + 10 * nw);
      chk("float at", t_f - t_g, 3);
      hold <= 0;
      while (address_oe !== 1'b1) @(posedge mclk);
      chk("grant off", bus_grant_ack, 0);
    end
    do bus(0, OFF_STAT, 0, x); while (x[STA_BUSY] !== 1'b0);
    chk("waits", n_w - w0, 10 * nw);
    if (k == 2 || k == 4 || k == 6) begin
      chk("wdata", {last_wa, last_wd}, {e[15:0], wd[7:0]});
      mem_m[e] = wd[7:0];
    end else chk("rdata", x[7:0], mval(e));
    if (k == 0 && !ia) pc = (pc + 1) & 16'hffff;
    if (k == 3) sp = (sp + 1) & 16'hffff;
    if (k == 4) sp = (sp - 1) & 16'hffff;
    rchk("pc", OFF_PC, pc);
    rchk("sp", OFF_SP, sp);
  endtask

  initial begin
    logic [31:0] x;
    repeat (3) @(posedge mclk);
    resetn <= 1;
    repeat (3) @(posedge mclk);
    x = $urandom(32'heafd);
    chk("reset pins", {irq_enable_out, bus_grant_ack, wr_n, address_oe}, 4'h3);
    rchk("pc reset", OFF_PC, PC_RST);
    bus(0, OFF_STAT, 0, x);
    chk("stat reset", x & 32'h3f00, 0);
    pc = $urandom & 16'hffff;
    sp = $urandom & 16'hffff;
    wreg(OFF_PC, pc);
    wreg(OFF_SP, sp);
    hold <= 1;
    repeat (40) @(posedge mclk);
    chk("hold idle", bus_grant_ack, 0);
    for (int k = 0; k < 7; k++) for (int r = 0; r < 2; r++) begin
      ra = $urandom & 16'hffff;
      wd = $urandom & 255;
      wreg(OFF_ADDR, ra);
      wreg(OFF_WDATA, wd);
      cyc(k, $urandom % 3, r == 1 && (k == 1 || k == 2), 0);
    end
    irq <= 1;
    wreg(OFF_CMD, 32'h40);
    stat("accept off", STA_INTACC, 0);
    wreg(OFF_CMD, 32'h10);
    @(posedge mclk);
    chk("ei", irq_enable_out, 1);
    wreg(OFF_CMD, 32'h30);
    @(posedge mclk);
    chk("ei di", irq_enable_out, 0);
    wreg(OFF_CMD, 32'h10);
    wreg(OFF_CMD, 32'h40);
    stat("accept", STA_INTACC, 1);
    cyc(0, 1, 0, 1);
    chk("ack clears", {st_ie, irq_enable_out}, 0);
    irq <= 0;
    wreg(OFF_CMD, 32'h10);
    wreg(OFF_CMD, 32'hf);
    repeat (30) @(posedge mclk);
    stat("halted", STA_HALTED, 1);
    irq <= 1;
    do bus(0, OFF_STAT, 0, x); while (x[STA_HALTED] !== 1'b0);
    chk("halt irq", x[STA_INTACC], 1);
    irq <= 0;
    resetn <= 0;
    repeat (3) @(posedge mclk);
    resetn <= 1;
    repeat (3) @(posedge mclk);
    rchk("pc again", OFF_PC, PC_RST);
    rchk("sp kept", OFF_SP, sp);
    chk("ie reset", irq_enable_out, 0);
    wreg(32'h18, 32'hffff_ffff);
    rchk("unmapped", 32'h18, 0);
    chk("wr stable", wr_bad, 0);
    test_done();
  end

  // Cuts a hang short; the full run needs well under a fifth of this
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule // cpu_bus_cycle_control_bench
`default_nettype wire
